// ===== rtl/rssc_seq.v
// reset and standby sequencer with pin state control
//
// Function
// [R1] While the interrupt pin is sampled low after power-up the device stays in manual reset.
// [R2] A high interrupt pin after power-up moves the device to power-on reset.
// [R3] While the standby pin is low the device stays in hardware standby with all pins floating.
// [R4] A high standby pin starts the oscillator, then the device enters power-on reset.
// [R5] Releasing reset starts power-on reset exception handling.
// [R6] The far side drives clear low at least ten states before standby falls to keep memory.
// [R7] The far side holds clear low until standby has fallen.
// [R8] With memory retention off the far side may enter standby without clear.
// [R9] The far side holds clear low and interrupt high about 100 ns before raising standby.
// [R10] In retained states input pins float and output pins keep their level; here select pins 1 to 3 drive high in software standby with standby_output_keep.
// [R11] In modes 4 to 6 select pins 1 to 3 drive high in manual reset after the bus cycle if set; here they float while nmi_seen_q is low.
// [R12] In modes 4 to 6 select pins 1 to 3 float in power-on reset, hardware standby, bus release.
// [R13] In modes 1 to 3 and 7 port g bit 3 floats in reset and hardware standby, else kept; here it is kept in manual reset once nmi_seen_q is set.
// [R14] A low standby pin forces hardware standby whatever clear and interrupt do.
`include "rssc_regs.vh"

module rssc_seq #(
    parameter OSC_SETTLE_NS = `RSSC_OSC_SETTLE_NS
) (
    // clock and reset
    input  wire       mclk,
    input  wire       srst,
    // device pins
    input  wire       hardware_standby_n,
    input  wire       external_clear_n,
    input  wire       nmi_level,
    // core side
    input  wire [2:0] mode,
    input  wire       internal_memory_enable,
    input  wire       standby_output_keep,
    input  wire       sw_standby,
    input  wire       bus_release,
    input  wire       cycle_done,
    input  wire [2:0] cs_ddr,
    input  wire [2:0] cs_func,
    input  wire       port_g_bit3_ddr,
    input  wire       port_g_bit3_dout,
    // status
    output reg        osc_enable,
    output reg        core_reset,
    output reg        exception_start,
    output reg        memory_retained,
    output reg        pins_float,
    // pins
    output reg  [2:0] area_select_n_out,
    output reg  [2:0] area_select_n_oe,
    output reg        port_g_bit3_out,
    output reg        port_g_bit3_oe
);

    localparam OSC_CYC = (OSC_SETTLE_NS + `RSSC_CLK_PERIOD_NS - 1) / `RSSC_CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg [2:0] sy1_q;
    reg [2:0] sy2_q;
    wire      standby_s;
    wire      clr_s;
    wire      nmi_s;

    always @(posedge mclk)
    begin
        if (srst)
        begin
            sy1_q <= `RSSC_SYNC_IDLE;
            sy2_q <= `RSSC_SYNC_IDLE;
        end
        else
        begin
            sy1_q <= {hardware_standby_n, external_clear_n, nmi_level};
            sy2_q <= sy1_q;
        end
    end

    assign standby_s = sy2_q[2];
    assign clr_s     = sy2_q[1];
    assign nmi_s     = sy2_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    reg [2:0]              st_q;
    reg [2:0]              st_d;
    reg [`RSSC_CNT_W-1:0]  cnt_q;
    reg [`RSSC_CNT_W-1:0]  cnt_d;
    reg                    nmi_seen_q;
    reg                    nmi_seen_d;
    reg                    mem_d;

    always @*
    begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        nmi_seen_d = nmi_seen_q;
        mem_d      = memory_retained;
        if (!standby_s)
        begin
            st_d  = `RSSC_ST_HWSTBY;                     // R3 R14
            cnt_d = `RSSC_CNT_ZERO;
            // retention only when clear was already low on standby entry
            if (st_q != `RSSC_ST_HWSTBY)
                mem_d = internal_memory_enable & ~clr_s; // R7 R8
        end
        else
        begin
            case (st_q)
                `RSSC_ST_HWSTBY:
                begin
                    st_d  = `RSSC_ST_OSC;                // R4
                    cnt_d = OSC_CYC[`RSSC_CNT_W-1:0];
                end
                `RSSC_ST_OSC:
                begin
                    if (cnt_q <= `RSSC_CNT_ONE)
                        st_d = `RSSC_ST_POR;             // R4
                    else
                        cnt_d = cnt_q - `RSSC_CNT_ONE;
                end
                `RSSC_ST_MANUAL:
                begin
                    if (nmi_s)
                    begin
                        st_d       = `RSSC_ST_POR;       // R2
                        nmi_seen_d = 1'b1;
                    end
                end
                `RSSC_ST_POR:
                begin
                    if (clr_s)
                        st_d = `RSSC_ST_EXCEPT;          // R5
                end
                `RSSC_ST_EXCEPT:
                begin
                    st_d  = `RSSC_ST_RUN;
                    mem_d = 1'b0;
                end
                `RSSC_ST_RUN:
                begin
                    // clear with the interrupt pin low is a manual reset
                    if (!clr_s)
                        st_d = nmi_s ? `RSSC_ST_POR : `RSSC_ST_MANUAL; // R11
                end
                default: st_d = `RSSC_ST_MANUAL;
            endcase
        end
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            // power-up: manual reset until the interrupt pin is seen high
            st_q            <= `RSSC_ST_MANUAL;               // R1
            cnt_q           <= `RSSC_CNT_ZERO;
            nmi_seen_q      <= 1'b0;
            memory_retained <= 1'b0;
            osc_enable      <= 1'b1;
            core_reset      <= 1'b1;
            exception_start <= 1'b0;
        end
        else
        begin
            st_q            <= st_d;
            cnt_q           <= cnt_d;
            nmi_seen_q      <= nmi_seen_d;
            memory_retained <= mem_d;
            osc_enable      <= (st_d != `RSSC_ST_HWSTBY);       // R4
            core_reset      <= (st_d != `RSSC_ST_RUN) && (st_d != `RSSC_ST_EXCEPT);
            exception_start <= (st_d == `RSSC_ST_EXCEPT);       // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin states

    reg  [2:0] ps;
    reg  [2:0] cs_last_q;
    wire [2:0] cs_o;
    wire [2:0] cs_e;
    wire       pg_o;
    wire       pg_e;

    always @*
    begin
        case (st_q)
            `RSSC_ST_HWSTBY,
            `RSSC_ST_OSC:    ps = `RSSC_PS_HWSTBY;
            `RSSC_ST_MANUAL: ps = nmi_seen_q ? `RSSC_PS_MANUAL : `RSSC_PS_POR;
            `RSSC_ST_RUN:    ps = sw_standby ? `RSSC_PS_SWSTBY :
                                  (bus_release ? `RSSC_PS_BUSREL : `RSSC_PS_EXEC);
            default:         ps = `RSSC_PS_POR;
        endcase
    end

    rssc_pin_state u_pins (
        .mode                (mode),
        .pstate              (ps),
        .cycle_done          (cycle_done),
        .cs_ddr              (cs_ddr),
        .standby_output_keep (standby_output_keep),
        .port_ddr            (port_g_bit3_ddr),
        .port_dout           (port_g_bit3_dout),
        .cs_func             (cs_func),
        .cs_last             (cs_last_q),
        .cs_out              (cs_o),
        .cs_oe               (cs_e),
        .port_out            (pg_o),
        .port_oe             (pg_e)
    );

    always @(posedge mclk)
    begin
        if (srst)
        begin
            cs_last_q         <= 3'h7;
            area_select_n_out <= 3'h7;
            area_select_n_oe  <= 3'h0;
            port_g_bit3_out   <= 1'b0;
            port_g_bit3_oe    <= 1'b0;
            pins_float        <= 1'b1;
        end
        else
        begin
            cs_last_q         <= cs_o;
            area_select_n_out <= cs_o;
            // hardware standby floats every pin
            area_select_n_oe  <= (st_d == `RSSC_ST_HWSTBY) ? 3'h0 : cs_e; // R3
            port_g_bit3_out   <= (pg_e && ps != `RSSC_PS_EXEC) ? port_g_bit3_out : pg_o; // R10
            port_g_bit3_oe    <= (st_d == `RSSC_ST_HWSTBY) ? 1'b0 : pg_e;
            pins_float        <= (st_d == `RSSC_ST_HWSTBY);
        end
    end

endmodule

// ===== pkg/rssc_regs.vh
// constants for the reset and standby sequencer with pin state control
`ifndef RSSC_REGS_VH
`define RSSC_REGS_VH

// sequencer states
`define RSSC_ST_HWSTBY      3'h0
`define RSSC_ST_OSC         3'h1
`define RSSC_ST_MANUAL      3'h2
`define RSSC_ST_POR         3'h3
`define RSSC_ST_EXCEPT      3'h4
`define RSSC_ST_RUN         3'h5

// operating mode codes
`define RSSC_MODE_W         3
`define RSSC_MODE_EXT_LO    3'h4
`define RSSC_MODE_EXT_HI    3'h6

// run-state codes on the pin-state unit
`define RSSC_PS_POR         3'h0
`define RSSC_PS_MANUAL      3'h1
`define RSSC_PS_HWSTBY      3'h2
`define RSSC_PS_SWSTBY      3'h3
`define RSSC_PS_BUSREL      3'h4
`define RSSC_PS_EXEC        3'h5

// oscillator settling time, clock period and settle counter width
`define RSSC_OSC_SETTLE_NS  1000
`define RSSC_CLK_PERIOD_NS  25
`define RSSC_CNT_W          8
`define RSSC_CNT_ZERO       8'h00
`define RSSC_CNT_ONE        8'h01

// synchroniser idle levels: standby high, clear low, interrupt low
`define RSSC_SYNC_IDLE      3'h4

`endif

// ===== rtl/rssc_pin_state.v
// pin driver state for the chip-select pins and port g bit 3
`include "rssc_regs.vh"

module rssc_pin_state (
    // mode and state
    input  wire [2:0] mode,
    input  wire [2:0] pstate,
    input  wire       cycle_done,
    // per-pin controls
    input  wire [2:0] cs_ddr,
    input  wire       standby_output_keep,
    input  wire       port_ddr,
    input  wire       port_dout,
    input  wire [2:0] cs_func,
    input  wire [2:0] cs_last,
    // resulting pin drive
    output wire [2:0] cs_out,
    output wire [2:0] cs_oe,
    output reg        port_out,
    output reg        port_oe
);

    wire ext_mode;
    assign ext_mode = (mode >= `RSSC_MODE_EXT_LO) && (mode <= `RSSC_MODE_EXT_HI);

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_cs
            reg out_b;
            reg oe_b;
            always @*
            begin
                out_b = 1'b1;
                oe_b  = 1'b0;
                if (ext_mode)
                begin
                    case (pstate)
                        `RSSC_PS_MANUAL:
                        begin
                            // drive high once the running bus cycle ends
                            out_b = cycle_done ? 1'b1 : cs_last[g]; // R11
                            oe_b  = cs_ddr[g];                       // R11
                        end
                        `RSSC_PS_SWSTBY:
                        begin
                            oe_b = cs_ddr[g] & standby_output_keep; // R10
                        end
                        `RSSC_PS_EXEC:
                        begin
                            out_b = cs_func[g];
                            oe_b  = cs_ddr[g];
                        end
                        default:
                        begin
                            oe_b = 1'b0; // R12
                        end
                    endcase
                end
            end
            assign cs_out[g] = out_b;
            assign cs_oe[g]  = oe_b;
        end
    endgenerate

    // port g bit 3 as general port outside the extended modes
    always @*
    begin
        port_out = port_dout;
        port_oe  = 1'b0;
        if (!ext_mode)
        begin
            case (pstate)
                `RSSC_PS_POR,
                `RSSC_PS_HWSTBY: port_oe = 1'b0;     // R13
                default:         port_oe = port_ddr; // R10 R13
            endcase
        end
    end

endmodule

// ===== tb/rssc_sup_model.sv
// external reset and power supervisor model driving the standby, clear and interrupt pins
module rssc_sup_model (
    // clock
    input  wire  mclk,
    // supervised pins
    output logic hardware_standby_n,
    output logic external_clear_n,
    output logic nmi_level
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        hardware_standby_n = 1'b1;
        external_clear_n   = 1'b0;
        nmi_level          = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic drive(input logic clr, input logic irq);
        external_clear_n = clr;
        nmi_level        = irq;
    endtask

    // enter hardware standby, retaining memory when asked
    task automatic enter(input bit keep);
        if (keep)
        begin
            external_clear_n = 1'b0;
            step(12);
        end
        hardware_standby_n = 1'b0;
        step(1);
        external_clear_n = 1'b1;
    endtask

    // leave hardware standby through a power-on reset
    task automatic leave();
        drive(1'b0, 1'b1);
        step(5);
        hardware_standby_n = 1'b1;
    endtask
endmodule

// ===== tb/rssc_seq_asserts.sv
// concurrent checks for the reset and standby sequencer
module rssc_seq_chk #(
    parameter OSC_SETTLE_NS = 1000
) (
    // clock and reset
    input wire       mclk,
    input wire       srst,
    // pins and core inputs
    input wire       hardware_standby_n,
    input wire       external_clear_n,
    input wire       internal_memory_enable,
    input wire       cycle_done,
    // status
    input wire       osc_enable,
    input wire       core_reset,
    input wire       exception_start,
    input wire       memory_retained,
    input wire       pins_float,
    // pin drive
    input wire [2:0] area_select_n_out,
    input wire [2:0] area_select_n_oe,
    input wire       port_g_bit3_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence standby_low;
        !hardware_standby_n [*4];
    endsequence
    sequence standby_rise;
        $rose(hardware_standby_n) ##1 hardware_standby_n [*3];
    endsequence

    standby_float_a: assert property (
        standby_low |-> pins_float && !osc_enable && area_select_n_oe == 3'h0)
        else $error("pins not floating in hardware standby");
    standby_prio_a: assert property (
        standby_low |-> core_reset && !exception_start)
        else $error("standby did not override clear and interrupt");
    osc_start_a: assert property (
        standby_rise |-> osc_enable)
        else $error("oscillator not started after standby release");
    except_cause_a: assert property (
        exception_start |-> $past(external_clear_n, 3) && !pins_float)
        else $error("exception handling without clear release");
    except_pulse_a: assert property (
        exception_start |=> !exception_start && !core_reset)
        else $error("exception start not a single pulse into run");
    mem_keep_a: assert property (
        $rose(memory_retained) |-> internal_memory_enable && !hardware_standby_n)
        else $error("memory retained without enable");
    select_high_a: assert property (
        core_reset && $past(core_reset) && $past(cycle_done)
            |-> (area_select_n_out & area_select_n_oe) == area_select_n_oe)
        else $error("select pin driven low during reset");
    port_float_a: assert property (
        pins_float |-> !port_g_bit3_oe)
        else $error("port g bit 3 driven while floating");
endmodule

bind rssc_seq rssc_seq_chk #(.OSC_SETTLE_NS(OSC_SETTLE_NS)) u_chk (
    .mclk(mclk), .srst(srst), .hardware_standby_n(hardware_standby_n),
    .external_clear_n(external_clear_n), .internal_memory_enable(internal_memory_enable),
    .cycle_done(cycle_done),
    .osc_enable(osc_enable), .core_reset(core_reset), .exception_start(exception_start),
    .memory_retained(memory_retained), .pins_float(pins_float),
    .area_select_n_out(area_select_n_out), .area_select_n_oe(area_select_n_oe),
    .port_g_bit3_oe(port_g_bit3_oe));

// ===== tb/tb_reset_standby_pin_state_control.sv
// testbench for the reset and standby sequencer
module tb_reset_standby_pin_state_control;
    timeunit 1ns;
    timeprecision 100ps;

    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic       imem = 1'b0;
    logic       sok  = 1'b0;
    logic       swsb = 1'b0;
    logic       brel = 1'b0;
    logic       pdir = 1'b0;
    logic       pdat = 1'b0;
    logic [2:0] mode = 3'h4;
    logic [2:0] cddr = 3'h7;
    logic       cdone = 1'b1;
    logic [2:0] cfun = 3'h5;
    wire        sby_n, clr_n, nmi, osc, crst, exc, mret, pflt, pg_out, pg_oe;
    wire  [2:0] cs_out, cs_oe;
    int         error_cnt = 0;
    int         tests_run = 0;

    rssc_seq #(.OSC_SETTLE_NS(100)) dut (
        .mclk(mclk), .srst(srst), .hardware_standby_n(sby_n), .external_clear_n(clr_n),
        .nmi_level(nmi), .mode(mode), .internal_memory_enable(imem), .standby_output_keep(sok),
        .sw_standby(swsb), .bus_release(brel), .cycle_done(cdone), .cs_ddr(cddr),
        .cs_func(cfun), .port_g_bit3_ddr(pdir), .port_g_bit3_dout(pdat), .osc_enable(osc),
        .core_reset(crst), .exception_start(exc), .memory_retained(mret), .pins_float(pflt),
        .area_select_n_out(cs_out), .area_select_n_oe(cs_oe), .port_g_bit3_out(pg_out),
        .port_g_bit3_oe(pg_oe));
    rssc_sup_model sup (.mclk(mclk), .hardware_standby_n(sby_n), .external_clear_n(clr_n),
        .nmi_level(nmi));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic wait_exc();
        for (int i = 0; i < 20 && exc !== 1'b1; i++)
            cyc(1);
        chk(exc, 1'b1);
        cyc(2);
        chk(crst, 1'b0);
    endtask

    task automatic results();
        $display("counts: %0d compares, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power();
        cyc(8);
        chk(crst, 1'b1);
        sup.drive(1'b0, 1'b1);
        cyc(6);
        chk(cs_oe, 3'h0);
        chk(exc, 1'b0);
        sup.drive(1'b1, 1'b1);
        wait_exc();
        $display("test power done");
    endtask

    task automatic t_select();
        swsb = 1'b1;
        sok  = 1'b1;
        cyc(4);
        chk(cs_oe & cs_out, 3'h7);
        sok = 1'b0;
        cyc(4);
        chk(cs_oe, 3'h0);
        swsb = 1'b0;
        brel = 1'b1;
        cyc(4);
        chk(cs_oe, 3'h0);
        brel = 1'b0;
        $display("test select pins done");
    endtask

    task automatic t_manual();
        cdone = 1'b0;
        cyc(2);
        chk(cs_out, cfun);
        sup.drive(1'b0, 1'b0);
        cyc(6);
        chk(crst, 1'b1);
        chk(cs_oe, 3'h7);
        chk(cs_out, cfun);
        cdone = 1'b1;
        cyc(2);
        chk(cs_out, 3'h7);
        cddr = 3'h2;
        cyc(2);
        chk(cs_oe, 3'h2);
        cddr = 3'h7;
        sup.drive(1'b0, 1'b1);
        cyc(4);
        chk(cs_oe, 3'h0);
        sup.drive(1'b1, 1'b1);
        wait_exc();
        $display("test manual reset done");
    endtask

    task automatic t_port();
        mode = 3'h2;
        pdir = 1'b1;
        pdat = 1'b1;
        cyc(4);
        swsb = 1'b1;
        cyc(4);
        pdat = 1'b0;
        cyc(4);
        chk({pg_oe, pg_out}, 2'b11);
        pdir = 1'b0;
        cyc(2);
        chk(pg_oe, 1'b0);
        swsb = 1'b0;
        $display("test port done");
    endtask

    task automatic t_standby(input bit keep);
        imem = keep;
        sup.enter(keep);
        cyc(4);
        chk({pflt, osc, pg_oe}, 3'b100);
        chk(crst, 1'b1);
        chk(mret, keep);
        sup.leave();
        cyc(4);
        chk(osc, 1'b1);
        cyc(8);
        chk({pflt, pg_oe}, 2'b00);
        sup.drive(1'b1, 1'b1);
        wait_exc();
        $display("test standby done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        #2;
        srst = 1'b0;
        t_power();
        t_select();
        t_manual();
        t_port();
        t_standby(1'b1);
        t_standby(1'b0);
        results();
    end

    initial
    begin
        repeat (2000) @(posedge mclk);
        error_cnt++;
        results();
    end
endmodule
